/* verilog/network_object_parameter_gateway.v */
// Gateway from network objects onto the 16-bit bypass register space
//
// Overview of operation
// RULE1 - State word bits 4..7 read-only status
// RULE2 - Fault word bits 0..7, bit 4 unused
// RULE3 - Alarm word bits 0,2,3,5 read-only
// RULE4 - Instance id 22 bits, from two settings
// RULE5 - Instance id change applies after power-up
// RULE6 - Writable 20-char name, applies after power-up
// RULE7 - Indirect read via address then data object
// RULE8 - Client writes address, then data value
// RULE9 - Indirect writes forwarded, stay pending until commit when the setting requires it
// RULE10 - RAM commit activates pending values only
// RULE11 - Save commit activates and stores nonvolatile
// RULE12 - Other objects act without any commit
// RULE13 - Setting decides if commit is needed
// RULE14 - Commit registers write-only, reads refused
// RULE15 - Commit objects read without error
// RULE16 - Client should limit save commit frequency
// RULE17 - Write during nonvolatile save gets busy; writes to the RAM commit object and the name are accepted
// RULE18 - Invalid register read gets read refused
// RULE19 - Out-of-range value gets bad value error
// RULE20 - Invalid, inhibited or undervoltage write refused
// RULE21 - Commit object returns to off after commit
`timescale 1ns/10ps
`default_nettype none
`include "gateway_consts.vh"
module network_object_parameter_gateway #(
  parameter NAME_BITS = 8 * `NAME_CHARS
) (
  input wire clk_sys_in,
  input wire srst_in,
  // Network object access
  input wire obj_req_in,
  input wire obj_write_in,
  input wire [2:0] obj_sel_in,
  input wire [21:0] obj_wdata_in,
  input wire [4:0] obj_name_idx_in,
  output wire obj_ack_out,
  output reg [21:0] obj_rdata_out,
  output reg [7:0] obj_err_out,
  // Settings and power-up
  input wire power_up_in,
  input wire [15:0] instance_id_setting_a_in,
  input wire [5:0] instance_id_setting_b_in,
  input wire commit_required_setting_in,
  // Bypass status sources
  input wire remote_transfer_state_in,
  input wire energy_save_state_in,
  input wire motor1_select_state_in,
  input wire motor2_select_state_in,
  input wire drive_fault_state_in,
  input wire safety_fault_state_in,
  input wire interlock_fault_state_in,
  input wire external_fault_state_in,
  input wire motor_overload_state_in,
  input wire motor1_overload_state_in,
  input wire motor2_overload_state_in,
  input wire input_phase_loss_state_in,
  input wire drive_link_loss_state_in,
  input wire option_link_loss_state_in,
  input wire load_loss_state_in,
  // Drive parameter store
  output reg store_req_out,
  output reg store_write_out,
  output reg [15:0] store_addr_out,
  output reg [15:0] store_wdata_out,
  input wire store_ack_in,
  input wire [15:0] store_rdata_in,
  input wire store_addr_valid_in,
  input wire store_value_valid_in,
  input wire store_saving_in,
  input wire store_write_inhibit_in,
  input wire store_undervoltage_in,
  output reg activate_ram_out,
  output reg activate_save_out,
  output reg [21:0] instance_id_out,
  output reg [NAME_BITS-1:0] device_name_out
);
  // ****************************************
  // State machine
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_STORE = 2'b01;
  localparam ST_DONE = 2'b10;
  reg [1:0] state;
  reg [15:0] indirect_addr;
  reg ram_commit_obj;
  reg save_commit_obj;
  reg pending;
  reg [21:0] instance_id_staged;
  reg [NAME_BITS-1:0] name_staged;
  reg [7:0] next_err;
  reg [21:0] next_rdata;
  reg local_hit;
  reg [15:0] status_word;
  wire [15:0] state_word;
  wire [15:0] fault_word;
  wire [15:0] alarm_word;
  wire [15:0] target_addr;
  wire is_commit_reg;
  wire commit_by_reg;
  wire name_idx_ok;

  // ****************************************
  // Status word bit placement
  // ****************************************
  // Unused positions read as zero
  assign state_word[3:0] = 4'h0;
  assign state_word[4] = remote_transfer_state_in; // RULE1
  assign state_word[5] = energy_save_state_in; // RULE1
  assign state_word[6] = motor1_select_state_in; // RULE1
  assign state_word[7] = motor2_select_state_in; // RULE1
  assign state_word[15:8] = 8'h00;
  assign fault_word[0] = drive_fault_state_in; // RULE2
  assign fault_word[1] = safety_fault_state_in; // RULE2
  assign fault_word[2] = interlock_fault_state_in; // RULE2
  assign fault_word[3] = external_fault_state_in; // RULE2
  assign fault_word[4] = 1'b0; // RULE2
  assign fault_word[5] = motor_overload_state_in; // RULE2
  assign fault_word[6] = motor1_overload_state_in; // RULE2
  assign fault_word[7] = motor2_overload_state_in; // RULE2
  assign fault_word[15:8] = 8'h00;
  assign alarm_word[0] = input_phase_loss_state_in; // RULE3
  assign alarm_word[1] = 1'b0;
  assign alarm_word[2] = drive_link_loss_state_in; // RULE3
  assign alarm_word[3] = option_link_loss_state_in; // RULE3
  assign alarm_word[4] = 1'b0;
  assign alarm_word[5] = load_loss_state_in; // RULE3
  assign alarm_word[15:6] = 10'h000;

  // ****************************************
  // Access decode
  // ****************************************
  assign target_addr = indirect_addr;
  assign is_commit_reg = (target_addr == `REG_SAVE_COMMIT) || (target_addr == `REG_RAM_COMMIT);
  // Writing the commit value to a commit register acts at once
  assign commit_by_reg = is_commit_reg && (obj_wdata_in[15:0] == `COMMIT_VALUE);
  // Name characters beyond the last one are not backed by storage
  assign name_idx_ok = (obj_name_idx_in < `NAME_CHARS);
  assign obj_ack_out = (state == ST_DONE);

  // ****************************************
  // Status words served locally
  // ****************************************
  always @* begin
    local_hit = 1'b1;
    status_word = 16'h0000;
    case (target_addr)
      `REG_BYPASS_STATE: status_word = state_word;
      `REG_BYPASS_FAULT: status_word = fault_word;
      `REG_BYPASS_ALARM: status_word = alarm_word;
      default: local_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Identity held until power-up
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      instance_id_staged <= 22'h000000;
      instance_id_out <= 22'h000000;
      device_name_out <= {NAME_BITS{1'b0}};
    end else begin
      instance_id_staged <= {instance_id_setting_b_in, instance_id_setting_a_in}; // RULE4
      if (power_up_in) begin
        instance_id_out <= instance_id_staged; // RULE5
        device_name_out <= name_staged; // RULE6
      end
    end
  end

  // ****************************************
  // Object access sequencing
  // ****************************************
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      indirect_addr <= 16'h0000;
      ram_commit_obj <= 1'b0;
      save_commit_obj <= 1'b0;
      pending <= 1'b0;
      name_staged <= {NAME_BITS{1'b0}};
      obj_rdata_out <= 22'h000000;
      obj_err_out <= `ERR_NONE;
      store_req_out <= 1'b0;
      store_write_out <= 1'b0;
      store_addr_out <= 16'h0000;
      store_wdata_out <= 16'h0000;
      activate_ram_out <= 1'b0;
      activate_save_out <= 1'b0;
    end else begin
      activate_ram_out <= 1'b0;
      activate_save_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (obj_req_in) begin
            state <= ST_DONE;
            obj_err_out <= `ERR_NONE;
            obj_rdata_out <= 22'h000000;
            case (obj_sel_in)
              `OBJ_INDIRECT_ADDRESS: begin
                if (obj_write_in) begin
                  indirect_addr <= obj_wdata_in[15:0]; // RULE7
                end
                obj_rdata_out <= {6'h00, indirect_addr};
              end
              `OBJ_INDIRECT_DATA: begin
                if (!obj_write_in && local_hit) begin
                  obj_rdata_out <= {6'h00, status_word}; // RULE7
                end else if (!obj_write_in && is_commit_reg) begin
                  obj_err_out <= `ERR_READ_REFUSED; // RULE14
                end else if (obj_write_in && local_hit) begin
                  obj_err_out <= `ERR_WRITE_REFUSED; // RULE20
                end else if (obj_write_in && commit_by_reg && !store_saving_in) begin
                  pending <= 1'b0;
                  activate_ram_out <= 1'b1; // RULE10
                  activate_save_out <= (target_addr == `REG_SAVE_COMMIT); // RULE11
                end else if (obj_write_in && store_saving_in) begin
                  obj_err_out <= `ERR_BUSY_SAVING; // RULE17
                end else if (obj_write_in && (store_write_inhibit_in || store_undervoltage_in)) begin
                  obj_err_out <= `ERR_WRITE_REFUSED; // RULE20
                end else if (obj_write_in && obj_wdata_in[21:16] != 6'h00) begin
                  obj_err_out <= `ERR_BAD_VALUE; // RULE19
                end else begin
                  state <= ST_STORE;
                  store_req_out <= 1'b1;
                  store_write_out <= obj_write_in;
                  store_addr_out <= target_addr;
                  store_wdata_out <= obj_wdata_in[15:0]; // RULE9
                end
              end
              `OBJ_RAM_COMMIT: begin
                obj_rdata_out <= {21'h000000, ram_commit_obj}; // RULE15
                if (obj_write_in && obj_wdata_in[0]) begin
                  ram_commit_obj <= 1'b1;
                  state <= ST_STORE;
                end
              end
              `OBJ_SAVE_COMMIT: begin
                obj_rdata_out <= {21'h000000, save_commit_obj}; // RULE15
                if (obj_write_in && obj_wdata_in[0]) begin
                  if (store_saving_in) begin
                    obj_err_out <= `ERR_BUSY_SAVING; // RULE17
                  end else begin
                    save_commit_obj <= 1'b1;
                    state <= ST_STORE;
                  end
                end
              end
              `OBJ_INSTANCE_ID: begin
                obj_rdata_out <= instance_id_out; // RULE12
              end
              `OBJ_DEVICE_NAME: begin
                if (!name_idx_ok) begin
                  obj_err_out <= obj_write_in ? `ERR_BAD_VALUE : `ERR_READ_REFUSED; // RULE19
                end else if (obj_write_in) begin
                  name_staged[obj_name_idx_in*8 +: 8] <= obj_wdata_in[7:0]; // RULE6
                end else begin
                  obj_rdata_out <= {14'h0000, device_name_out[obj_name_idx_in*8 +: 8]}; // RULE6
                end
              end
              default: begin
                obj_err_out <= obj_write_in ? `ERR_WRITE_REFUSED : `ERR_READ_REFUSED;
              end
            endcase
          end
        end
        ST_STORE: begin
          // Commit objects finish here, one cycle after being taken
          if (ram_commit_obj || save_commit_obj) begin
            activate_ram_out <= 1'b1; // RULE10
            activate_save_out <= save_commit_obj; // RULE11
            pending <= 1'b0;
            ram_commit_obj <= 1'b0; // RULE21
            save_commit_obj <= 1'b0; // RULE21
            state <= ST_DONE;
          end else if (store_ack_in) begin
            store_req_out <= 1'b0;
            state <= ST_DONE;
            if (!store_addr_valid_in) begin
              obj_err_out <= store_write_out ? `ERR_WRITE_REFUSED : `ERR_READ_REFUSED; // RULE18
            end else if (store_write_out && !store_value_valid_in) begin
              obj_err_out <= `ERR_BAD_VALUE; // RULE19
            end else if (store_write_out) begin
              if (commit_required_setting_in) begin
                pending <= 1'b1; // RULE13
              end else begin
                activate_ram_out <= 1'b1; // RULE13
              end
            end else begin
              obj_rdata_out <= {6'h00, store_rdata_in}; // RULE7
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* verilog/gateway_consts.vh */
// Constants for the network object parameter gateway
`ifndef GATEWAY_CONSTS_VH
`define GATEWAY_CONSTS_VH
`define REG_SAVE_COMMIT 16'h0900
`define REG_RAM_COMMIT 16'h0910
`define REG_BYPASS_STATE 16'h8785
`define REG_BYPASS_FAULT 16'h8786
`define REG_BYPASS_ALARM 16'h8787
`define COMMIT_VALUE 16'h0000
`define ERR_NONE 8'h00
`define ERR_BUSY_SAVING 8'h03
`define ERR_READ_REFUSED 8'h1b
`define ERR_BAD_VALUE 8'h25
`define ERR_WRITE_REFUSED 8'h28
`define OBJ_INDIRECT_ADDRESS 3'h0
`define OBJ_INDIRECT_DATA 3'h1
`define OBJ_RAM_COMMIT 3'h2
`define OBJ_SAVE_COMMIT 3'h3
`define OBJ_INSTANCE_ID 3'h4
`define OBJ_DEVICE_NAME 3'h5
`define INSTANCE_ID_MAX 22'h3fffff
`define NAME_CHARS 20
`endif

/* testbench/gateway_checker.sv */
// Port assertions for the network object parameter gateway
`timescale 1ns/10ps
`default_nettype none
module gateway_checker (
  input wire logic clk_sys_in, srst_in, obj_ack_out, store_req_out, store_write_out, store_ack_in,
  input wire logic store_addr_valid_in, store_value_valid_in, activate_ram_out, activate_save_out,
  input wire logic power_up_in,
  input wire logic [7:0] obj_err_out,
  input wire logic [21:0] instance_id_out
);
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  wire ans = store_req_out && store_ack_in;
  a_reset_clears: assert property ($fell(srst_in) |-> !obj_ack_out && !store_req_out && instance_id_out == 22'h0)
    else $error("outputs not cleared");
  a_ack_pulse: assert property (obj_ack_out |=> !obj_ack_out) else $error("long ack");
  a_req_holds: assert property (store_req_out && !store_ack_in |=> store_req_out) else $error("req dropped");
  a_store_answer: assert property (ans |=> obj_ack_out) else $error("no answer");
  a_read_refused: assert property (ans && !store_write_out && !store_addr_valid_in |=> obj_err_out == 8'h1b)
    else $error("bad read code");
  a_addr_refused: assert property (ans && store_write_out && !store_addr_valid_in |=> obj_err_out == 8'h28)
    else $error("bad write code");
  a_value_refused: assert property (ans && store_write_out && store_addr_valid_in && !store_value_valid_in
    |=> obj_err_out == 8'h25) else $error("bad value code");
  a_save_with_ram: assert property (activate_save_out |-> activate_ram_out ##1 !activate_save_out)
    else $error("save pulse");
  a_id_held: assert property (!power_up_in |=> $stable(instance_id_out)) else $error("id moved");
  c_save: cover property (activate_save_out);
  c_write: cover property (ans && store_write_out);
  c_power: cover property (power_up_in);
endmodule
bind network_object_parameter_gateway gateway_checker i_chk (.clk_sys_in, .srst_in, .obj_ack_out, .store_req_out,
  .store_write_out, .store_ack_in, .store_addr_valid_in, .store_value_valid_in, .activate_ram_out,
  .activate_save_out, .power_up_in, .obj_err_out, .instance_id_out);
`default_nettype wire

/* testbench/store_model.sv */
// Behavioural parameter store facing the gateway
`timescale 1ns/10ps
`default_nettype none
module store_model (
  input wire logic clk_sys_in, srst_in, slow_in, req_in,
  input wire logic [15:0] addr_in, wdata_in,
  output logic ack_out, addr_valid_out, value_valid_out,
  output logic [15:0] rdata_out
);
  // ****************
  // Answer pacing
  // ****************
  logic [1:0] cnt;
  logic [15:0] tick = 16'h0;
  always @(posedge clk_sys_in) begin
    tick <= tick + 16'h1;
    ack_out <= 1'b0;
    cnt <= 2'h0;
    if (!srst_in && req_in && !ack_out) begin
      if (cnt == {slow_in, slow_in}) ack_out <= 1'b1;
      else cnt <= cnt + 2'h1;
    end
  end
  // Answers hold only with ack, a moving pattern otherwise
  assign rdata_out = ack_out ? addr_in ^ 16'h5a5a : tick;
  assign addr_valid_out = ack_out ? addr_in[15:12] != 4'hf : tick[0];
  assign value_valid_out = ack_out ? wdata_in < 16'h1000 : tick[1];
endmodule
`default_nettype wire

/* testbench/network_object_parameter_gateway_tb.sv */
// Self-checking bench for the network object parameter gateway
`timescale 1ns/10ps
`default_nettype none
`include "gateway_consts.vh"
module network_object_parameter_gateway_tb;
  logic clk = 1'b0, srst = 1'b1, req = 1'b0, wr = 1'b0, pw = 1'b0, creq = 1'b0, slow = 1'b0;
  logic [2:0] sel = 3'h0, flg = 3'h0;
  logic [21:0] wd = 22'h0, got, eid = 22'h0;
  logic [15:0] ida = 16'h0, a;
  logic [5:0] idb = 6'h0;
  logic [4:0] nidx = 5'h13;
  logic [14:0] st = 15'h0, s;
  logic [7:0] gerr, ech = 8'h0, ch;
  wire ack, sreq, swr, sack, sav, svv, aram, asave;
  wire [7:0] err;
  wire [21:0] rd, iid;
  wire [15:0] sad, swd, srd;
  wire [159:0] nm;
  int miscompares = 0, checks = 0, nram = 0, nsave = 0, n0, n1;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (aram === 1'b1) nram <= nram + 1;
    if (asave === 1'b1) nsave <= nsave + 1;
  end
  network_object_parameter_gateway i_dut (.clk_sys_in(clk), .srst_in(srst), .obj_req_in(req), .obj_write_in(wr),
    .obj_sel_in(sel), .obj_wdata_in(wd), .obj_name_idx_in(nidx), .obj_ack_out(ack), .obj_rdata_out(rd),
    .obj_err_out(err), .power_up_in(pw), .instance_id_setting_a_in(ida), .instance_id_setting_b_in(idb),
    .commit_required_setting_in(creq), .remote_transfer_state_in(st[0]), .energy_save_state_in(st[1]),
    .motor1_select_state_in(st[2]), .motor2_select_state_in(st[3]), .drive_fault_state_in(st[4]),
    .safety_fault_state_in(st[5]), .interlock_fault_state_in(st[6]), .external_fault_state_in(st[7]),
    .motor_overload_state_in(st[8]), .motor1_overload_state_in(st[9]), .motor2_overload_state_in(st[10]),
    .input_phase_loss_state_in(st[11]), .drive_link_loss_state_in(st[12]), .option_link_loss_state_in(st[13]),
    .load_loss_state_in(st[14]), .store_req_out(sreq), .store_write_out(swr), .store_addr_out(sad),
    .store_wdata_out(swd), .store_ack_in(sack), .store_rdata_in(srd), .store_addr_valid_in(sav),
    .store_value_valid_in(svv), .store_saving_in(flg[2]), .store_write_inhibit_in(flg[1]),
    .store_undervoltage_in(flg[0]), .activate_ram_out(aram), .activate_save_out(asave),
    .instance_id_out(iid), .device_name_out(nm));
  store_model i_store (.clk_sys_in(clk), .srst_in(srst), .slow_in(slow), .req_in(sreq), .addr_in(sad),
    .wdata_in(swd), .ack_out(sack), .addr_valid_out(sav), .value_valid_out(svv), .rdata_out(srd));
  // ****************
  // Tasks
  // ****************
  function automatic logic [21:0] stat(input int w, input logic [14:0] v);
    if (w == 0) return {14'h0, v[3:0], 4'h0};
    if (w == 1) return {14'h0, v[10:8], 1'b0, v[7:4]};
    return {16'h0, v[14], 1'b0, v[13:12], 1'b0, v[11]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] o, input logic [21:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    sel <= o;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    got = rd;
    gerr = err;
    req <= 1'b0;
    chk(32'(n < 40), 32'h1, "ack");
  endtask
  task automatic ind(input logic w, input logic [15:0] ad, input logic [21:0] v, input logic [7:0] ee, input string t);
    acc(1'b1, `OBJ_INDIRECT_ADDRESS, {6'h0, ad});
    acc(w, `OBJ_INDIRECT_DATA, w ? v : 22'h0);
    chk(32'(gerr), 32'(ee), t);
    if (!w && ee == 8'h0) chk(32'(got), 32'(v), t);
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    conclude;
  end
  initial begin
    void'($urandom(32'ha78c));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      s = i ? 15'($urandom) : 15'h7fff;
      st <= s;
      for (int j = 0; j < 3; j++) ind(1'b0, 16'(`REG_BYPASS_STATE + j), stat(j, s), 8'h0, "status");
    end
    ind(1'b1, `REG_BYPASS_FAULT, 22'h1, `ERR_WRITE_REFUSED, "status write");
    repeat (5) begin
      a = 16'($urandom) & 16'h7fff | 16'h1000;
      slow <= 1'($urandom);
      ind(1'b0, a, {6'h0, a ^ 16'h5a5a}, 8'h0, "param read");
    end
    ind(1'b0, 16'hf123, 22'h0, `ERR_READ_REFUSED, "bad read");
    ind(1'b0, `REG_SAVE_COMMIT, 22'h0, `ERR_READ_REFUSED, "save reg read");
    ind(1'b0, `REG_RAM_COMMIT, 22'h0, `ERR_READ_REFUSED, "ram reg read");
    creq <= 1'b1;
    n0 = nram;
    repeat (3) ind(1'b1, 16'h1000 | 16'($urandom) & 16'h0fff, 22'($urandom) & 22'hfff, 8'h0, "write");
    chk(nram, n0, "pending");
    creq <= 1'b0;
    ind(1'b1, 16'h2345, 22'h7, 8'h0, "direct write");
    repeat (2) @(posedge clk);
    chk(nram, n0 + 1, "direct activate");
    for (int k = 0; k < 6; k++) begin
      flg <= k < 3 ? 3'b100 >> k : 3'b000;
      ind(1'b1, k == 3 ? 16'hf000 : 16'h1234, k == 4 ? 22'h2000 : k == 5 ? 22'h10000 : 22'h5,
        k == 0 ? `ERR_BUSY_SAVING : k < 4 ? `ERR_WRITE_REFUSED : `ERR_BAD_VALUE, "refusal");
    end
    flg <= 3'b000;
    n0 = nram;
    n1 = nsave;
    acc(1'b1, `OBJ_RAM_COMMIT, 22'h1);
    acc(1'b1, `OBJ_SAVE_COMMIT, 22'h1);
    ind(1'b1, `REG_RAM_COMMIT, 22'(`COMMIT_VALUE), 8'h0, "ram reg");
    ind(1'b1, `REG_SAVE_COMMIT, 22'(`COMMIT_VALUE), 8'h0, "save reg");
    repeat (2) @(posedge clk);
    chk(nram, n0 + 4, "ram activations");
    chk(nsave, n1 + 2, "save activations");
    for (int o = 2; o < 4; o++) begin
      acc(1'b0, 3'(o), 22'h0);
      chk(32'({gerr, got}), 32'h0, "commit object");
    end
    flg <= 3'b100;
    acc(1'b1, `OBJ_SAVE_COMMIT, 22'h1);
    chk(32'(gerr), 32'(`ERR_BUSY_SAVING), "save commit busy");
    flg <= 3'b000;
    nidx <= 5'($urandom % 20);
    for (int i = 0; i < 2; i++) begin
      ida <= i ? 16'($urandom) : 16'hffff;
      idb <= i ? 6'($urandom) : 6'h3f;
      ch = 8'($urandom);
      acc(1'b1, `OBJ_DEVICE_NAME, {14'h0, ch});
      chk(32'({nm[nidx*8 +: 8], iid}), 32'({ech, eid}), "before power-up");
      eid = {idb, ida};
      ech = ch;
      pw <= 1'b1;
      @(posedge clk);
      pw <= 1'b0;
      @(posedge clk);
      chk(32'({nm[nidx*8 +: 8], iid}), 32'({ech, eid}), "after power-up");
    end
    acc(1'b0, `OBJ_DEVICE_NAME, 22'h0);
    chk(32'({gerr, got}), 32'({8'h0, 14'h0, ech}), "name read");
    nidx <= 5'h14;
    acc(1'b1, `OBJ_DEVICE_NAME, 22'h55);
    chk(32'(gerr), 32'(`ERR_BAD_VALUE), "name index write");
    acc(1'b0, `OBJ_DEVICE_NAME, 22'h0);
    chk(32'(gerr), 32'(`ERR_READ_REFUSED), "name index read");
    conclude;
  end
endmodule
`default_nettype wire
